/* hdl/and_ops_carry_branch_exec.sv */
// Quarter-phase executor for the literal AND, the register AND and the carry branch.
// Assumes program memory and data memory sit on the same clock; data memory returns
// read data in the same clock that a read request is seen on its port.
module and_ops_carry_branch_exec (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [15:0] instr_word_in,
    input wire logic carry_in,
    input wire logic ext_set_en_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [and_ops_carry_branch_exec_pkg::ADDR_W-1:0] index_base_in,
    input wire logic [7:0] mem_rdata_in,
    output logic [and_ops_carry_branch_exec_pkg::PC_W-1:0] pc_out,
    output and_ops_carry_branch_exec_pkg::mem_req_t mem_req_out,
    output logic [7:0] working_out,
    output logic negative_out,
    output logic zero_out,
    output and_ops_carry_branch_exec_pkg::phase_t phase_out,
    output logic nop_cycle_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    and_ops_carry_branch_exec_pkg::phase_t phase_r, phase_nxt;
    logic [15:0] instr_r, instr_nxt;
    logic [and_ops_carry_branch_exec_pkg::PC_W-1:0] pc_r, pc_nxt;
    logic [7:0] w_r, w_nxt;
    logic neg_r, neg_nxt;
    logic zero_r, zero_nxt;
    logic nop_r, nop_nxt;
    logic [7:0] result_r, result_nxt;
    and_ops_carry_branch_exec_pkg::mem_req_t req_r, req_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the held instruction word.

    logic is_and_lit;
    logic is_and_file;
    logic is_branch;
    logic dest_file;
    logic [7:0] f_addr;
    logic [and_ops_carry_branch_exec_pkg::ADDR_W-1:0] data_addr;
    logic [and_ops_carry_branch_exec_pkg::PC_W-1:0] branch_ofs;

    always_comb begin
        is_and_lit = (instr_r[15:8] == and_ops_carry_branch_exec_pkg::OPC_AND_LITERAL);
        is_and_file = (instr_r[15:10] == and_ops_carry_branch_exec_pkg::OPC_AND_FILE);
        is_branch = (instr_r[15:8] == and_ops_carry_branch_exec_pkg::OPC_BRANCH_CARRY);
        dest_file = instr_r[and_ops_carry_branch_exec_pkg::DEST_BIT];
        f_addr = instr_r[7:0];
        // Twice the signed offset, sign-extended to the full counter width.
        branch_ofs = {{(and_ops_carry_branch_exec_pkg::PC_W - 9){instr_r[7]}}, instr_r[7:0], 1'b0};
        if (instr_r[and_ops_carry_branch_exec_pkg::ACCESS_BIT]) begin
            data_addr = {bank_select_register_in, f_addr};
        end else if (ext_set_en_in && (f_addr <= and_ops_carry_branch_exec_pkg::INDEXED_LIMIT)) begin
            // The offset wraps within the data space rather than faulting.
            data_addr = index_base_in + {4'h0, f_addr};
        end else if (f_addr >= and_ops_carry_branch_exec_pkg::ACCESS_SPLIT) begin
            data_addr = {and_ops_carry_branch_exec_pkg::ACCESS_HI_BANK, f_addr};
        end else begin
            data_addr = {and_ops_carry_branch_exec_pkg::ACCESS_LO_BANK, f_addr};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Branch decision, shared by the sequencer and the program counter.

    logic take_branch;

    always_comb begin
        take_branch = (phase_r == and_ops_carry_branch_exec_pkg::PH_WRITE) && !nop_r
            && is_branch && carry_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase sequencer and no-operation cycle.

    always_comb begin
        phase_nxt = phase_r;
        nop_nxt = nop_r;
        unique case (phase_r)
            and_ops_carry_branch_exec_pkg::PH_DECODE: begin
                phase_nxt = and_ops_carry_branch_exec_pkg::PH_READ;
            end
            and_ops_carry_branch_exec_pkg::PH_READ: begin
                phase_nxt = and_ops_carry_branch_exec_pkg::PH_PROCESS;
            end
            and_ops_carry_branch_exec_pkg::PH_PROCESS: begin
                phase_nxt = and_ops_carry_branch_exec_pkg::PH_WRITE;
            end
            and_ops_carry_branch_exec_pkg::PH_WRITE: begin
                phase_nxt = and_ops_carry_branch_exec_pkg::PH_DECODE;
                // A taken branch spends one whole instruction cycle idle, so nothing
                // is fetched or executed until the counter holds the target.
                if (nop_r) begin
                    nop_nxt = 1'h0;
                end else if (take_branch) begin
                    nop_nxt = 1'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            phase_r <= and_ops_carry_branch_exec_pkg::PH_DECODE;
            nop_r <= and_ops_carry_branch_exec_pkg::FLAG_RESET;
        end else begin
            phase_r <= phase_nxt;
            nop_r <= nop_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction latch and program counter.

    always_comb begin
        instr_nxt = instr_r;
        pc_nxt = pc_r;
        if ((phase_r == and_ops_carry_branch_exec_pkg::PH_DECODE) && !nop_r) begin
            instr_nxt = instr_word_in;
            pc_nxt = pc_r + and_ops_carry_branch_exec_pkg::PC_STEP;
        end else if (take_branch) begin
            // The counter already points past the branch, so the target adds only 2n.
            pc_nxt = pc_r + branch_ofs;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            instr_r <= and_ops_carry_branch_exec_pkg::INSTR_RESET;
            pc_r <= and_ops_carry_branch_exec_pkg::PC_RESET;
        end else begin
            instr_r <= instr_nxt;
            pc_r <= pc_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath: result, working register and flags.

    always_comb begin
        result_nxt = result_r;
        w_nxt = w_r;
        neg_nxt = neg_r;
        zero_nxt = zero_r;
        // The result is held for one phase so that the write phase sees a settled
        // value, whatever the memory does after its read pulse ends.
        if (phase_r == and_ops_carry_branch_exec_pkg::PH_PROCESS) begin
            if (is_and_lit) begin
                result_nxt = w_r & instr_r[7:0];
            end else begin
                result_nxt = w_r & mem_rdata_in;
            end
        end else if ((phase_r == and_ops_carry_branch_exec_pkg::PH_WRITE) && !nop_r) begin
            if (is_and_lit) begin
                w_nxt = result_r;
                neg_nxt = result_r[7];
                zero_nxt = (result_r == 8'h00);
            end else if (is_and_file) begin
                neg_nxt = result_r[7];
                zero_nxt = (result_r == 8'h00);
                if (!dest_file) begin
                    w_nxt = result_r;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            result_r <= and_ops_carry_branch_exec_pkg::RESULT_RESET;
            w_r <= and_ops_carry_branch_exec_pkg::W_RESET;
            neg_r <= and_ops_carry_branch_exec_pkg::FLAG_RESET;
            zero_r <= and_ops_carry_branch_exec_pkg::FLAG_RESET;
        end else begin
            result_r <= result_nxt;
            w_r <= w_nxt;
            neg_r <= neg_nxt;
            zero_r <= zero_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data memory request.

    always_comb begin
        // Both strobes are one-cycle pulses; a strobe left high would read or
        // write the same location a second time.
        req_nxt = and_ops_carry_branch_exec_pkg::MEM_REQ_IDLE;
        if ((phase_r == and_ops_carry_branch_exec_pkg::PH_READ) && !nop_r && is_and_file) begin
            req_nxt.addr = data_addr;
            req_nxt.rd_en = 1'h1;
        end else if ((phase_r == and_ops_carry_branch_exec_pkg::PH_WRITE) && !nop_r
            && is_and_file && dest_file) begin
            req_nxt.addr = data_addr;
            req_nxt.wdata = result_r;
            req_nxt.wr_en = 1'h1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            req_r <= and_ops_carry_branch_exec_pkg::MEM_REQ_IDLE;
        end else begin
            req_r <= req_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    always_comb begin
        pc_out = pc_r;
        mem_req_out = req_r;
        working_out = w_r;
        negative_out = neg_r;
        zero_out = zero_r;
        phase_out = phase_r;
        nop_cycle_out = nop_r;
    end

endmodule : and_ops_carry_branch_exec

/* hdl/and_ops_carry_branch_exec_pkg.sv */
// Constants and carrier types for the AND and carry-branch executor.
// Assumes one 40 MHz core clock and a synchronous, active-low reset.
// Summary of operation
// - An opcode high byte of 0000 1011 ANDs the unsigned 8-bit literal with the working register.
// - The literal AND writes the working register and updates only the negative and zero flags.
// - An opcode starting 0001 01 ANDs the working register with the addressed file register and updates negative and zero.
// - For the register AND a destination bit of zero writes the working register and one writes the file register.
// - An access bit of zero selects the access bank and one takes the bank from the bank select register.
// - With the extended set on and the access bit zero, a file address up to 5Fh is an indexed literal offset.
// - A carry branch with carry set loads the program counter with its value plus two plus twice the signed offset, flags untouched.
// - A taken carry branch lasts two instruction cycles, the second a no-operation, and an untaken one lasts one.
package and_ops_carry_branch_exec_pkg;

    localparam int PC_W = 21;
    localparam int ADDR_W = 12;

    localparam logic [7:0] OPC_AND_LITERAL = 8'h0B;
    localparam logic [5:0] OPC_AND_FILE = 6'h05;
    localparam logic [7:0] OPC_BRANCH_CARRY = 8'hE2;

    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;

    localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    // All ones after reset, so the first AND passes its operand through instead of
    // forcing every later result to zero.
    localparam logic [7:0] W_RESET = 8'hFF;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'h0;
    localparam logic [15:0] INSTR_RESET = 16'h0000;

    typedef enum logic [3:0] {
        PH_DECODE = 4'h1,
        PH_READ = 4'h2,
        PH_PROCESS = 4'h4,
        PH_WRITE = 4'h8
    } phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic rd_en;
        logic wr_en;
    } mem_req_t;

    localparam mem_req_t MEM_REQ_IDLE = '{addr: 12'h000, wdata: 8'h00, rd_en: 1'b0, wr_en: 1'b0};

endpackage : and_ops_carry_branch_exec_pkg

/* verif/and_exec_props_properties.sv */
// Checker for the AND and carry-branch executor, bound to its top ports.
// Assumes one clock and the synchronous active-low reset.
module and_exec_props (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [15:0] instr_word_in,
    input wire logic carry_in,
    input wire logic [3:0] bank_select_register_in,
    input wire logic [7:0] mem_rdata_in,
    input wire logic [20:0] pc_out,
    input wire and_ops_carry_branch_exec_pkg::mem_req_t mem_req_out,
    input wire logic [7:0] working_out,
    input wire logic negative_out,
    input wire logic zero_out,
    input wire and_ops_carry_branch_exec_pkg::phase_t phase_out,
    input wire logic nop_cycle_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic go;
    logic [7:0] lo;
    logic [20:0] off2;
    assign go = phase_out == 4'h1 && !nop_cycle_out;
    assign lo = instr_word_in[7:0];
    assign off2 = {{12{lo[7]}}, lo, 1'b0};
    property p_ring;
        phase_out == 4'h2 |=> phase_out == 4'h4 ##1 phase_out == 4'h8 ##1 phase_out == 4'h1;
    endproperty
    a_ring: assert property (p_ring) else $error("phase order broken");
    property p_pc;
        go |=> pc_out == $past(pc_out) + 21'h2;
    endproperty
    a_pc: assert property (p_pc) else $error("pc step wrong");
    property p_rd;
        mem_req_out.rd_en |-> phase_out == 4'h4;
    endproperty
    a_rd: assert property (p_rd) else $error("read outside process");
    property p_wr;
        mem_req_out.wr_en |-> mem_req_out.wdata == (working_out & $past(mem_rdata_in, 2));
    endproperty
    a_wr: assert property (p_wr) else $error("write data wrong");
    property p_lit;
        go && instr_word_in[15:8] == 8'h0B |-> ##4 working_out == ($past(working_out, 4)
            & $past(lo, 4)) && zero_out == (working_out == 8'h00) && negative_out == working_out[7];
    endproperty
    a_lit: assert property (p_lit) else $error("literal and wrong");
    property p_file;
        go && instr_word_in[15:10] == 6'h05 |-> ##2 mem_req_out.rd_en
            ##2 mem_req_out.wr_en == |($past(instr_word_in, 4) & 16'h0200);
    endproperty
    a_file: assert property (p_file) else $error("register and wrong");
    property p_bank;
        go && instr_word_in[15:10] == 6'h05 && instr_word_in[8]
            |-> ##2 mem_req_out.addr == {bank_select_register_in, $past(lo, 2)};
    endproperty
    a_bank: assert property (p_bank) else $error("bank address wrong");
    property p_taken;
        go && instr_word_in[15:8] == 8'hE2 ##3 carry_in |=> nop_cycle_out [*4] ##1 !nop_cycle_out;
    endproperty
    a_taken: assert property (p_taken) else $error("taken branch length wrong");
    property p_target;
        go && instr_word_in[15:8] == 8'hE2 ##3 carry_in
            |=> pc_out == $past(pc_out, 3) + $past(off2, 4) && $stable(zero_out);
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");
    property p_skip;
        go && instr_word_in[15:8] == 8'hE2 ##3 !carry_in |=> !nop_cycle_out && $stable(pc_out);
    endproperty
    a_skip: assert property (p_skip) else $error("untaken branch wrong");
    cover property (go && instr_word_in[15:8] == 8'hE2 ##3 carry_in);
    cover property (mem_req_out.wr_en);
    cover property (go && instr_word_in[15:8] == 8'h0B);
endmodule : and_exec_props
bind and_ops_carry_branch_exec and_exec_props i_props (.clk_sys_in, .rst_n_in, .instr_word_in,
    .carry_in, .bank_select_register_in, .mem_rdata_in, .pc_out, .mem_req_out, .working_out,
    .negative_out, .zero_out, .phase_out, .nop_cycle_out);

/* verif/prog_data_mem.sv */
// Program and data memory model beside the executor.
// Assumes the bench fills the program array before it releases reset.
module prog_data_mem (
    input wire logic [20:0] pc_in,
    input wire and_ops_carry_branch_exec_pkg::mem_req_t req_in,
    output logic [15:0] instr_out,
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] words [0:7];
    logic [7:0] val;
    assign instr_out = words[pc_in[3:1]];
    // Data depends on the bank too, so a wrong bank cannot hide.
    assign val = req_in.addr[7:0] ^ {req_in.addr[11:8], req_in.addr[11:8]};
    // Outside a read the bus shows the inverse, never a stale copy.
    assign rdata_out = req_in.rd_en ? val : ~val;
endmodule : prog_data_mem

/* verif/and_ops_carry_branch_exec_test.sv */
// Self-checking bench for the AND and carry-branch executor.
// Assumes the design and the memory model share one 40 MHz clock.
module and_ops_carry_branch_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic carry = 1'b0;
    logic ext = 1'b0;
    logic [15:0] instr;
    logic [7:0] rdata;
    logic [20:0] pc;
    and_ops_carry_branch_exec_pkg::mem_req_t req;
    and_ops_carry_branch_exec_pkg::phase_t ph;
    logic [7:0] w;
    logic neg, zero, nop;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    and_ops_carry_branch_exec i_dut (.clk_sys_in(clk), .rst_n_in(rst_n), .instr_word_in(instr),
        .carry_in(carry), .ext_set_en_in(ext), .bank_select_register_in(4'h3),
        .index_base_in(12'h100), .mem_rdata_in(rdata), .pc_out(pc), .mem_req_out(req),
        .working_out(w), .negative_out(neg), .zero_out(zero), .phase_out(ph), .nop_cycle_out(nop));
    prog_data_mem i_mem (.pc_in(pc), .req_in(req), .instr_out(instr), .rdata_out(rdata));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            err_count++;
            close_out();
        end
    end
    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Each scenario restarts from reset, which also cuts the previous run short.
    task automatic start(input logic [15:0] word, input logic [15:0] next_word);
        for (int i = 0; i < 8; i++) i_mem.words[i] = 16'hFFFF;
        i_mem.words[0] = word;
        i_mem.words[1] = next_word;
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
    endtask : start
    // Two literal ANDs in a row: the first from the reset value, the second on top of it.
    task automatic t_lit(input logic [7:0] k0, input logic [7:0] k1, input logic [7:0] ew);
        logic [7:0] e0;
        e0 = and_ops_carry_branch_exec_pkg::W_RESET & k0;
        start({8'h0B, k0}, {8'h0B, k1});
        @(negedge clk);
        chk("pc", 21'h2, pc);
        repeat (3) @(negedge clk);
        chk("w", {13'h0, e0}, {13'h0, w});
        chk("nz", {19'h0, e0[7], e0 == 8'h00}, {19'h0, neg, zero});
        repeat (4) @(negedge clk);
        chk("w", {13'h0, ew}, {13'h0, w});
        chk("nz", {19'h0, ew[7], ew == 8'h00}, {19'h0, neg, zero});
        chk("pc", 21'h4, pc);
    endtask : t_lit
    // The memory model answers a read of address a with a[7:0] ^ {a[11:8], a[11:8]}, given as md.
    task automatic t_file(input logic [15:0] word, input logic e, input logic [11:0] ea,
        input logic [7:0] md);
        logic [7:0] r;
        logic [7:0] wd;
        logic [7:0] ew;
        r = and_ops_carry_branch_exec_pkg::W_RESET & md;
        wd = word[9] ? r : 8'h00;
        ew = word[9] ? and_ops_carry_branch_exec_pkg::W_RESET : r;
        ext = e;
        start(word, 16'hFFFF);
        repeat (2) @(negedge clk);
        chk("rd", {8'h0, 1'b1, ea}, {8'h0, req.rd_en, req.addr});
        repeat (2) @(negedge clk);
        chk("wr", {12'h0, word[9], wd}, {12'h0, req.wr_en, req.wdata});
        chk("w", {13'h0, ew}, {13'h0, w});
        chk("nz", {19'h0, r[7], r == 8'h00}, {19'h0, neg, zero});
    endtask : t_file
    task automatic t_bc(input logic c, input logic [7:0] n, input logic [20:0] epc);
        carry = c;
        start({8'hE2, n}, 16'hFFFF);
        repeat (4) @(negedge clk);
        chk("pc", epc, pc);
        chk("nop", {20'h0, c}, {20'h0, nop});
        chk("z", 21'h0, {20'h0, zero});
        repeat (4) @(negedge clk);
        chk("nop", 21'h0, {20'h0, nop});
        chk("pc", epc + {19'h0, !c, 1'h0}, pc);
    endtask : t_bc
    task automatic close_out;
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    initial begin
        t_lit(8'hA3, 8'h5F, 8'h03);
        t_lit(8'h0F, 8'hF0, 8'h00);
        t_file(16'h1712, 1'b0, 12'h312, 8'h21);
        t_file(16'h1490, 1'b0, 12'hF90, 8'h6F);
        t_file(16'h141F, 1'b0, 12'h01F, 8'h1F);
        t_file(16'h145F, 1'b1, 12'h15F, 8'h4E);
        t_file(16'h1660, 1'b1, 12'h060, 8'h60);
        t_file(16'h1590, 1'b1, 12'h390, 8'hA3);
        t_file(16'h1733, 1'b0, 12'h333, 8'h00);
        t_bc(1'b1, 8'h7F, 21'h000100);
        t_bc(1'b1, 8'h80, 21'h1FFF02);
        t_bc(1'b0, 8'h05, 21'h000002);
        close_out();
    end
endmodule : and_ops_carry_branch_exec_test
